// ---- core/eic_ctrl.sv ----
// Functional notes
// - configured edge with interrupt unmasked raises request and sets pending
// - writing 1 to pending bit clears it and withdraws the request
// - configured edge with event unmasked gives one event pulse, no pending
// - software trigger with event unmasked gives one event pulse, no pending
// - software trigger with interrupt unmasked raises request and sets pending
// - event pulses drive the core wake-up-on-event input
// - lines 0 to 15 take pin n of a selectable port A,B,C,E,F,G
// - lines 16 to 19: voltage detector, rtc alarm, usb wake, ethernet wake
// - lines 20 to 31 have no source and never request anything
// - mask bits block at 0, pass at 1, both reset to 0; here they come in on cfg and sys_rst leaves them unchanged
// - rising and falling enabled together trigger on both edges
// - pending clears on write of 1 or on edge polarity change
// - software trigger bit stays set until its pending bit is written 1
`timescale 1ns/100ps
`include "eic_params.svh"

module eic_ctrl #(
   parameter int NUM_LINES  = `EIC_USED_LINES,
   parameter int GPIO_LINES = `EIC_GPIO_LINES,
   parameter int GPIO_PORTS = `EIC_GPIO_PORTS
) (
   input  wire logic                                  core_clk,
   input  wire logic                                  sys_rst,
   input  wire eic_pkg::eic_cfg_t                     cfg,
   input  wire logic [GPIO_LINES-1:0][2:0]            port_sel,
   input  wire eic_pkg::eic_wr_t                      sw_trig_wr,
   input  wire eic_pkg::eic_wr_t                      pend_clr_wr,
   input  wire logic [GPIO_PORTS-1:0][GPIO_LINES-1:0] gpio_pins,
   input  wire eic_pkg::eic_int_src_t                 int_src,
   output logic [31:0]                                irq_req,
   output logic [31:0]                                pending,
   output logic [31:0]                                sw_trig,
   output logic [31:0]                                evt_line,
   output logic                                       core_wake_evt
);

   // ===================================================================
   // elaboration checks
   // refused while elaborating, so a bad map never reaches a netlist
   if (NUM_LINES != `EIC_USED_LINES) begin
      $error("eic_ctrl: line map is fixed at 20 lines");
   end
   if (GPIO_LINES != `EIC_GPIO_LINES || GPIO_PORTS != `EIC_GPIO_PORTS) begin
      $error("eic_ctrl: gpio map is fixed at 6 ports of 16 pins");
   end

   // ===================================================================
   // functions
   function automatic logic pick_pin(
      input logic [GPIO_PORTS-1:0][GPIO_LINES-1:0] pins,
      input logic [2:0]                            sel,
      input int                                    n
   );
      logic hit;
      hit = 1'b0;
      // unused codes select nothing, so the line sits idle
      if (int'(sel) < GPIO_PORTS) begin
         hit = pins[sel][n];
      end
      return hit;
   endfunction

   // reserved lines 20 to 31 are forced to zero wherever state is formed
   function automatic logic [31:0] legal(input logic [31:0] v);
      return v & `EIC_LINE_MASK;
   endfunction

   // ===================================================================
   // input synchronisers
   // pins and wake sources are asynchronous; nothing reads them before two flops
   logic [GPIO_PORTS-1:0][GPIO_LINES-1:0] gpio_sync;
   eic_pkg::eic_int_src_t                 int_sync;

   eic_sync #(
      .WIDTH (GPIO_PORTS*GPIO_LINES)
   ) u_gpio_sync (
      .core_clk (core_clk),
      .sys_rst  (sys_rst),
      .async_in (gpio_pins),
      .sync_out (gpio_sync)
   );

   eic_sync #(
      .WIDTH ($bits(eic_pkg::eic_int_src_t))
   ) u_int_sync (
      .core_clk (core_clk),
      .sys_rst  (sys_rst),
      .async_in (int_src),
      .sync_out (int_sync)
   );

   // ===================================================================
   // line source selection
   logic [31:0] line_lvl;

   // a port_sel change can look like an edge; mask the line before moving it
   always_comb begin
      line_lvl = `EIC_RST_ZERO;
      for (int n = 0; n < GPIO_LINES; n++) begin
         line_lvl[n] = pick_pin(gpio_sync, port_sel[n], n);
      end
      line_lvl[`EIC_LINE_SVD] = int_sync.supply_voltage_detector;
      line_lvl[`EIC_LINE_RTC] = int_sync.rtc_alarm;
      line_lvl[`EIC_LINE_USB] = int_sync.usb_wake;
      line_lvl[`EIC_LINE_ETH] = int_sync.eth_wake;
   end

   // ===================================================================
   // edge detection state
   logic [31:0] lvl_prev_r;
   logic [31:0] lvl_prev_nxt;
   logic [31:0] rise_prev_r;
   logic [31:0] rise_prev_nxt;
   logic [31:0] fall_prev_r;
   logic [31:0] fall_prev_nxt;
   logic [31:0] rise_hit;
   logic [31:0] fall_hit;
   logic [31:0] hw_edge;
   logic [31:0] pol_change;

   always_comb begin
      lvl_prev_nxt  = legal(line_lvl);
      // last cycle's enables are kept so that a polarity change can clear pending
      rise_prev_nxt = legal(cfg.rise_en);
      fall_prev_nxt = legal(cfg.fall_en);
      rise_hit      = line_lvl & ~lvl_prev_r & cfg.rise_en;
      fall_hit      = ~line_lvl & lvl_prev_r & cfg.fall_en;
      // each enable is checked on its own, so both together act on both edges
      hw_edge = legal(rise_hit | fall_hit);
      pol_change = legal((cfg.rise_en ^ rise_prev_r) |
                         (cfg.fall_en ^ fall_prev_r));
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         lvl_prev_r  <= `EIC_RST_ZERO;
         rise_prev_r <= `EIC_RST_ZERO;
         fall_prev_r <= `EIC_RST_ZERO;
      end else begin
         lvl_prev_r  <= lvl_prev_nxt;
         rise_prev_r <= rise_prev_nxt;
         fall_prev_r <= fall_prev_nxt;
      end
   end

   // ===================================================================
   // software trigger bits
   logic [31:0] sw_trig_nxt;
   logic [31:0] sw_fire;
   logic [31:0] sw_set;
   logic [31:0] pend_clr;

   always_comb begin
      sw_set   = sw_trig_wr.wr ? legal(sw_trig_wr.data) : `EIC_RST_ZERO;
      pend_clr = pend_clr_wr.wr ? legal(pend_clr_wr.data) : `EIC_RST_ZERO;
      // only a 0-to-1 write fires; rewriting a held 1 does nothing
      sw_fire  = sw_set & ~sw_trig;
      // a pending clear also drops the trigger bit, so the line can fire again
      // a new write wins over a same-cycle clear
      sw_trig_nxt = (sw_trig & ~pend_clr) | sw_set;
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         sw_trig <= `EIC_RST_ZERO;
      end else begin
         sw_trig <= sw_trig_nxt;
      end
   end

   // ===================================================================
   // pending bits and interrupt requests
   logic [31:0] pend_set;
   logic [31:0] pending_nxt;
   logic [31:0] irq_nxt;

   always_comb begin
      // a masked edge is dropped; unmasking later brings nothing back
      pend_set = (hw_edge | sw_fire) & legal(cfg.int_mask);
      // set wins over clear so a simultaneous edge is not lost
      pending_nxt = (pending & ~pend_clr & ~pol_change) | pend_set;
      // request follows pending; mask only gates new sets
      irq_nxt = pending_nxt;
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         pending <= `EIC_RST_ZERO;
         irq_req <= `EIC_RST_ZERO;
      end else begin
         pending <= pending_nxt;
         irq_req <= irq_nxt;
      end
   end

   // ===================================================================
   // event pulses, never latched
   logic [31:0] evt_nxt;
   logic        wake_nxt;

   always_comb begin
      // a masked event is lost; events have no pending bit to catch them
      evt_nxt  = (hw_edge | sw_fire) & legal(cfg.evt_mask);
      wake_nxt = |evt_nxt;
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         evt_line      <= `EIC_RST_ZERO;
         core_wake_evt <= 1'b0;
      end else begin
         evt_line      <= evt_nxt;
         core_wake_evt <= wake_nxt;
      end
   end

endmodule

// ---- inc/eic_params.svh ----
`ifndef EIC_PARAMS_SVH
`define EIC_PARAMS_SVH

// ======================================================================
// line map
`define EIC_WORD_W        32
`define EIC_USED_LINES    20
`define EIC_GPIO_LINES    16
`define EIC_GPIO_PORTS    6
`define EIC_LINE_SVD      16
`define EIC_LINE_RTC      17
`define EIC_LINE_USB      18
`define EIC_LINE_ETH      19

// ======================================================================
// reset values and field masks
`define EIC_RST_ZERO      32'h0000_0000
`define EIC_LINE_MASK     32'h000F_FFFF

// ======================================================================
// synchroniser depth
`define EIC_SYNC_STAGES   2

`endif

// ---- inc/eic_pkg.sv ----
package eic_pkg;

   // ===================================================================
   // gpio port select codes
   typedef enum logic [2:0] {
      EIC_PORT_A = 3'h0,
      EIC_PORT_B = 3'h1,
      EIC_PORT_C = 3'h2,
      EIC_PORT_E = 3'h3,
      EIC_PORT_F = 3'h4,
      EIC_PORT_G = 3'h5
   } eic_port_t;

   // ===================================================================
   // configuration levels, held by software
   typedef struct packed {
      logic [31:0] int_mask;
      logic [31:0] evt_mask;
      logic [31:0] rise_en;
      logic [31:0] fall_en;
   } eic_cfg_t;

   // ===================================================================
   // one-cycle write strobe with its data
   typedef struct packed {
      logic        wr;
      logic [31:0] data;
   } eic_wr_t;

   // ===================================================================
   // internal wake-up sources
   typedef struct packed {
      logic eth_wake;
      logic usb_wake;
      logic rtc_alarm;
      logic supply_voltage_detector;
   } eic_int_src_t;

endpackage

// ---- core/eic_sync.sv ----
`timescale 1ns/100ps
`include "eic_params.svh"

module eic_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             core_clk,
   input  wire logic             sys_rst,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_r;
   logic [WIDTH-1:0] meta_nxt;
   logic [WIDTH-1:0] sync_nxt;

   if (WIDTH < 1) begin
      $error("eic_sync: WIDTH must be at least 1");
   end

   // first stage feeds only the second
   always_comb begin
      meta_nxt = async_in;
      sync_nxt = meta_r;
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         meta_r   <= '0;
         sync_out <= '0;
      end else begin
         meta_r   <= meta_nxt;
         sync_out <= sync_nxt;
      end
   end

endmodule

// ---- dv/eic_ctrl_chk.sv ----
`timescale 1ns/100ps
module eic_ctrl_chk #(
   parameter int NUM_LINES  = 20,
   parameter int GPIO_LINES = 16,
   parameter int GPIO_PORTS = 6
) (
   input wire logic                                  core_clk,
   input wire logic                                  sys_rst,
   input wire eic_pkg::eic_cfg_t                     cfg,
   input wire logic [GPIO_LINES-1:0][2:0]            port_sel,
   input wire eic_pkg::eic_wr_t                      sw_trig_wr,
   input wire eic_pkg::eic_wr_t                      pend_clr_wr,
   input wire logic [GPIO_PORTS-1:0][GPIO_LINES-1:0] gpio_pins,
   input wire eic_pkg::eic_int_src_t                 int_src,
   input wire logic [31:0]                           irq_req,
   input wire logic [31:0]                           pending,
   input wire logic [31:0]                           sw_trig,
   input wire logic [31:0]                           evt_line,
   input wire logic                                  core_wake_evt
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   // ====================================================================
   // line 0 software write on a clear trigger bit
   sequence sw0_s;
      sw_trig_wr.wr && sw_trig_wr.data[0] && !sw_trig[0];
   endsequence
   rsv_zero_a: assert property ((irq_req | pending | sw_trig | evt_line) >> 20 == 0)
      else $error("reserved line output set");
   irq_pend_a: assert property (irq_req == pending)
      else $error("request differs from pending");
   wake_or_a: assert property (core_wake_evt == (|evt_line))
      else $error("wake pulse not tied to line events");
   swirq0_a: assert property (sw0_s ##0 cfg.int_mask[0] |=> pending[0] && sw_trig[0])
      else $error("software interrupt not pended");
   swevt0_a: assert property (sw0_s ##0 cfg.evt_mask[0] |=> evt_line[0] ##1 !evt_line[0])
      else $error("software event pulse wrong");
   clr0_a: assert property (pend_clr_wr.wr && pend_clr_wr.data[0] && !sw_trig_wr.wr
                            |=> !pending[0] && !sw_trig[0])
      else $error("pending clear ignored");
   imask0_a: assert property ($rose(pending[0]) |-> $past(cfg.int_mask[0]))
      else $error("masked line pended");
   emask0_a: assert property (evt_line[0] |-> $past(cfg.evt_mask[0]))
      else $error("masked line gave event");
endmodule

// ---- dv/eic_core_model.sv ----
`timescale 1ns/100ps
module eic_core_model (
   input wire logic        core_clk,
   input wire logic        sys_rst,
   input wire logic [31:0] irq_req,
   input wire logic [31:0] chan_en,
   input wire logic        core_wake_evt,
   output int              wake_cnt,
   output logic            irq_taken
);
   // handler entry only for channels enabled in the core
   assign irq_taken = |(irq_req & chan_en);
   always @(posedge core_clk) begin
      if (sys_rst) wake_cnt <= 0;
      else if (core_wake_evt) wake_cnt <= wake_cnt + 1;
   end
endmodule

// ---- dv/external_line_irq_event_ctrl_tb_top.sv ----
`timescale 1ns/100ps
module external_line_irq_event_ctrl_tb_top;
   typedef struct packed {
      logic [4:0] ln; logic [2:0] prt; logic ri, fa, im, em, xp; logic [1:0] xe;
   } eic_row_t;
   logic core_clk = 0, sys_rst = 1, irq_taken;
   eic_pkg::eic_cfg_t cfg = '0;
   logic [15:0][2:0] port_sel = '0;
   eic_pkg::eic_wr_t sw_trig_wr = '0, pend_clr_wr = '0;
   logic [5:0][15:0] gpio_pins = '0;
   eic_pkg::eic_int_src_t int_src = '0;
   logic [31:0] irq_req, pending, sw_trig, evt_line;
   logic core_wake_evt;
   int n_fail = 0, samples_checked = 0, wake_cnt, evt_cnt = 0, evt_sum = 0, cur = 0;
   eic_row_t rows [11] = '{
      '{5'h00,3'h0,1,0,1,1,1,2'h1}, '{5'h05,3'h5,0,1,0,1,0,2'h1},
      '{5'h0F,3'h3,1,1,1,0,1,2'h0}, '{5'h03,3'h2,1,0,1,1,1,2'h1},
      '{5'h09,3'h4,0,1,1,0,1,2'h0}, '{5'h07,3'h1,1,0,0,0,0,2'h0},
      '{5'h10,3'h0,1,0,1,1,1,2'h1}, '{5'h11,3'h0,0,1,1,0,1,2'h0},
      '{5'h12,3'h0,1,0,0,1,0,2'h1}, '{5'h13,3'h0,1,1,0,1,0,2'h2},
      '{5'h04,3'h6,1,0,1,1,0,2'h0}};
   eic_ctrl u_dut (.core_clk(core_clk), .sys_rst(sys_rst), .cfg(cfg), .port_sel(port_sel),
      .sw_trig_wr(sw_trig_wr), .pend_clr_wr(pend_clr_wr), .gpio_pins(gpio_pins),
      .int_src(int_src), .irq_req(irq_req), .pending(pending), .sw_trig(sw_trig),
      .evt_line(evt_line), .core_wake_evt(core_wake_evt));
   eic_core_model u_core (.core_clk(core_clk), .sys_rst(sys_rst), .irq_req(irq_req),
      .chan_en(32'h000F_FFFF), .core_wake_evt(core_wake_evt), .wake_cnt(wake_cnt),
      .irq_taken(irq_taken));
   initial forever #20 core_clk = ~core_clk;
   always @(negedge core_clk) begin
      evt_cnt += evt_line[cur];
      evt_sum += core_wake_evt;
   end
   task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected %s: expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic cyc(int n);
      repeat (n) @(negedge core_clk);
   endtask
   task automatic strobe(logic clr, logic [31:0] d);
      if (clr) pend_clr_wr = '{1'b1, d};
      else sw_trig_wr = '{1'b1, d};
      cyc(1);
      if (clr) pend_clr_wr = '0;
      else sw_trig_wr = '0;
   endtask
   task automatic drv(int ln, int p, logic v);
      // port codes 6 and 7 have no pins to drive
      if (ln >= 16) int_src[ln-16] = v;
      else if (p < 6) gpio_pins[p][ln] = v;
   endtask
   task automatic conclude();
      if (n_fail == 0 && samples_checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      #400000;
      n_fail++;
      conclude();
   end
   initial begin
      cyc(8);
      sys_rst = 0;
      chk("pend_rst", pending | sw_trig | irq_req | evt_line, 32'h0000_0000);
      foreach (rows[i]) begin
         cur = rows[i].ln;
         if (cur < 16) port_sel[cur] = rows[i].prt;
         // edges and masks set first, as software must
         cfg = '{32'(rows[i].im) << cur, 32'(rows[i].em) << cur,
                 32'(rows[i].ri) << cur, 32'(rows[i].fa) << cur};
         cyc(2);
         evt_cnt = 0;
         if (cur < 16) gpio_pins[(rows[i].prt + 1) % 6][cur] = 1'b1;
         drv(cur, rows[i].prt, 1'b1);
         cyc(5);
         drv(cur, rows[i].prt, 1'b0);
         cyc(5);
         chk("pending", 32'(pending[cur]), 32'(rows[i].xp));
         chk("evt_cnt", evt_cnt, 32'(rows[i].xe));
         strobe(1, 32'hFFFF_FFFF);
         chk("pend_clr", pending, 32'h0000_0000);
         cfg = '0;
         cyc(1);
         gpio_pins = '0;
         cyc(4);
      end
      // software trigger on line 0, then a repeat write that must not fire
      cur = 0;
      cfg.int_mask = 32'hFFFF_FFFF;
      cfg.evt_mask = 32'hFFFF_FFFF;
      strobe(0, 32'h0000_0001);
      chk("sw_evt", evt_line, 32'h0000_0001);
      chk("sw_pend", pending & irq_req, 32'h0000_0001);
      chk("irq_taken", irq_taken, 32'h0000_0001);
      cyc(1);
      strobe(0, 32'h0000_0001);
      chk("sw_again", evt_line, 32'h0000_0000);
      chk("sw_hold", sw_trig, 32'h0000_0001);
      strobe(1, 32'h0000_0001);
      chk("sw_clr", sw_trig | pending, 32'h0000_0000);
      chk("irq_idle", irq_taken, 32'h0000_0000);
      strobe(0, 32'hFFF0_0000);
      chk("rsv", sw_trig | pending | evt_line, 32'h0000_0000);
      cyc(1);
      strobe(0, 32'h0000_0002);
      cfg.fall_en[1] = 1'b1;
      cyc(1);
      chk("pol_clr", pending, 32'h0000_0000);
      chk("pol_sw", sw_trig, 32'h0000_0002);
      cyc(2);
      chk("wake_cnt", wake_cnt, evt_sum);
      chk("wake_sum", evt_sum, 32'h0000_0009);
      // reset again with a trigger bit standing, then a request at the first edge
      sys_rst = 1'b1;
      cyc(2);
      chk("rst_mid", sw_trig | pending | irq_req | evt_line, 32'h0000_0000);
      sys_rst = 1'b0;
      strobe(0, 32'h0000_0004);
      chk("rst_first", sw_trig & pending, 32'h0000_0004);
      conclude();
   end
endmodule
bind eic_ctrl eic_ctrl_chk #(.NUM_LINES(NUM_LINES), .GPIO_LINES(GPIO_LINES),
   .GPIO_PORTS(GPIO_PORTS)) u_chk (.core_clk(core_clk), .sys_rst(sys_rst), .cfg(cfg),
   .port_sel(port_sel), .sw_trig_wr(sw_trig_wr), .pend_clr_wr(pend_clr_wr),
   .gpio_pins(gpio_pins), .int_src(int_src), .irq_req(irq_req), .pending(pending),
   .sw_trig(sw_trig), .evt_line(evt_line), .core_wake_evt(core_wake_evt));
